/* File: logic/lsl_pkg.sv */
// ==========================================================
// shared constants of the led shift-latch link
package lsl_pkg;

  // word layout
  localparam int WORD_BITS = 16;
  localparam int MSB_POS = WORD_BITS - 1;
  localparam int CNT_W = 5;

  // synchroniser depth for everything arriving from the link
  localparam int SYNC_STAGES = 2;

  // reset values
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [WORD_BITS-1:0] LATCH_RESET = 16'h0000;
  localparam logic BLANK_RESET = 1'h1;

  // timing of the link as the host makes it
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_HALF_NS = 40;
  localparam int LOAD_HIGH_NS = 40;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_HIGH_CYC = (LOAD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: logic/lsl_if.sv */
`timescale 1ns/1ns
// ==========================================================
// four-wire link plus the cascade output
interface lsl_if;
  logic serial_clk;
  logic serial_in;
  logic serial_out;
  logic latch_load;
  logic output_blank_n;

  modport host (
    output serial_clk,
    output serial_in,
    output latch_load,
    output output_blank_n,
    input serial_out
  );

  modport device (
    input serial_clk,
    input serial_in,
    input latch_load,
    input output_blank_n,
    output serial_out
  );
endinterface

/* File: logic/lsl_sync.sv */
`timescale 1ns/1ns
// ==========================================================
// two flip-flop synchroniser, one per bit
module lsl_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // the first stage feeds the second and nothing else
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

/* File: logic/lsl_device.sv */
`timescale 1ns/1ns
// ==========================================================
// Overview of operation
// - each link clock rise shifts serial_in in
// - host sends msb first, D15 down to D0
// - one word is sixteen bits, sixteen rises
// - serial_out is last stage, sixteen rises later
// - latch follows shift register while latch_load high
// - latch_load fall freezes latch until high again
// - blank high floats all sinks, latch kept
// - blank low lets sinks follow latch bits
// - shifting and latching ignore the blank input
// - host holds serial_in stable around rises
// - chains pass serial_out on, sixteen per driver
module lsl_device #(
  parameter int WIDTH = lsl_pkg::WORD_BITS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  lsl_if.device link,
  // open-drain led sink pins
  input wire logic [WIDTH-1:0] led_sink_in,
  output logic [WIDTH-1:0] led_sink_out,
  output logic [WIDTH-1:0] led_sink_oe,
  // status
  output logic [WIDTH-1:0] latch_value,
  output logic [WIDTH-1:0] led_sense,
  output logic [lsl_pkg::CNT_W-1:0] shift_count,
  output logic word_full,
  output logic outputs_blanked
);

  import lsl_pkg::*;

  // ========================================================
  // link synchronisers
  // all four link inputs go through the same depth, so data and
  // clock keep their relative timing after the crossing
  // limitation: a link phase shorter than two clock periods can be lost,
  // which caps the link clock at a quarter of clk
  // the synchronisers reset to zero, the idle level of clock and load
  logic [3:0] link_raw;
  logic [3:0] link_s;

  assign link_raw = {link.serial_clk, link.serial_in, link.latch_load, link.output_blank_n};

  lsl_sync #(
    .WIDTH(4)
  ) u_link_sync (
    .clk(clk),
    .rst(rst),
    .d(link_raw),
    .q(link_s)
  );

  wire sclk_s = link_s[3];
  wire din_s = link_s[2];
  wire load_s = link_s[1];
  wire blank_s = link_s[0];

  // pin levels read back, also crossed in two stages
  lsl_sync #(
    .WIDTH(WIDTH)
  ) u_sense_sync (
    .clk(clk),
    .rst(rst),
    .d(led_sink_in),
    .q(led_sense)
  );

  // ========================================================
  // link clock edge detection
  logic sclk_d_r;
  logic load_d_r;

  // the delayed copies reset to the idle levels of their pins, so the
  // release of reset never shows up as an edge
  function automatic logic went_high(input logic now_lvl, input logic was_lvl);
    went_high = now_lvl & ~was_lvl;
  endfunction

  wire sclk_rise = went_high(sclk_s, sclk_d_r);
  wire load_fall = went_high(~load_s, ~load_d_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_r <= 1'h0;
      load_d_r <= 1'h0;
    end else begin
      sclk_d_r <= sclk_s;
      load_d_r <= load_s;
    end
  end

  // ========================================================
  // shift register
  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] shift_nxt;

  // msb-first arrival means the first bit ends up in the top stage
  assign shift_nxt = sclk_rise ? {shift_r[WIDTH-2:0], din_s} : shift_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= SHIFT_RESET;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // cascade output straight from the last flip-flop stage
  assign link.serial_out = shift_r[WIDTH-1];

  // ========================================================
  // output latch
  logic [WIDTH-1:0] latch_r;
  logic [WIDTH-1:0] latch_nxt;

  // transparent while high; on the fall the last followed value stays,
  // which is the shift register at the fall
  // the blank level plays no part, so pwm on it cannot disturb a load
  assign latch_nxt = load_s ? shift_nxt : latch_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_r <= LATCH_RESET;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  assign latch_value = latch_r;

  // ========================================================
  // word progress
  // counts rises since the last load, saturating, so software can
  // see whether a whole word has gone past this stage
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  // stops at one word: in a chain each stage sees more rises than that,
  // so the flag only tells that this stage holds a whole word
  localparam logic [CNT_W-1:0] COUNT_FULL = CNT_W'(WIDTH);
  localparam logic [CNT_W-1:0] COUNT_ONE = CNT_W'(1);

  wire count_clear = load_s | load_fall;
  wire count_sat = (count_r == COUNT_FULL);

  always_comb begin
    count_nxt = count_r;
    if (count_clear) begin
      count_nxt = '0;
    end else if (sclk_rise && !count_sat) begin
      count_nxt = count_r + COUNT_ONE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign shift_count = count_r;

  // ========================================================
  // sink drivers
  // open drain: the pin is only ever pulled low; a zero latch bit or
  // the blank input release it, and the output enable is the control
  logic [WIDTH-1:0] sink_oe_r;
  logic [WIDTH-1:0] sink_oe_nxt;
  logic word_full_r;
  logic word_full_nxt;

  assign outputs_blanked = blank_s;
  // decoded from the next count so the flag lines up with shift_count
  assign word_full_nxt = (count_nxt == COUNT_FULL);

  // one sink per latch bit, bit n driving pin n
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_sink
      assign led_sink_out[gi] = 1'b0;
      assign sink_oe_nxt[gi] = latch_r[gi] & ~blank_s;
    end
  endgenerate

  // registered, so a latch update and a blank change that land in
  // the same cycle reach the pins together, with no decode glitch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sink_oe_r <= '0;
      word_full_r <= 1'h0;
    end else begin
      sink_oe_r <= sink_oe_nxt;
      word_full_r <= word_full_nxt;
    end
  end

  assign led_sink_oe = sink_oe_r;
  assign word_full = word_full_r;

endmodule

/* File: logic/lsl_host.sv */
`timescale 1ns/1ns
// ==========================================================
// host end: makes the link clock by division, shifts a frame for a
// chain of drivers msb first, then pulses latch_load
module lsl_host #(
  parameter int NUM_DEV = 1,
  parameter int HALF_CYC = lsl_pkg::LINK_HALF_CYC,
  parameter int LOAD_CYC = lsl_pkg::LOAD_HIGH_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  lsl_if.host link,
  // user request
  input wire logic start,
  input wire logic [NUM_DEV*lsl_pkg::WORD_BITS-1:0] frame_data,
  input wire logic blank_req,
  // user answer
  output logic busy,
  output logic done,
  output logic [NUM_DEV*lsl_pkg::WORD_BITS-1:0] readback
);

  import lsl_pkg::*;

  localparam int TOTAL = NUM_DEV * WORD_BITS;
  localparam int FW = TOTAL;
  localparam int BW = $clog2(TOTAL + 1);
  localparam int PW = $clog2(HALF_CYC + LOAD_CYC + 1);
  localparam logic [BW-1:0] BITS_ALL = BW'(TOTAL);
  localparam logic [BW-1:0] BITS_ONE = BW'(1);
  localparam logic [PW-1:0] PH_HALF = PW'(HALF_CYC - 1);
  localparam logic [PW-1:0] PH_LOAD = PW'(LOAD_CYC - 1);
  localparam logic [PW-1:0] PH_ONE = PW'(1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10,
    ST_LOAD = 2'b11
  } lsl_st_t;

  // ========================================================
  // cascade return path
  logic sout_s;

  lsl_sync #(
    .WIDTH(1)
  ) u_sout_sync (
    .clk(clk),
    .rst(rst),
    .d(link.serial_out),
    .q(sout_s)
  );

  // ========================================================
  // state
  lsl_st_t st_r, st_nxt;
  logic [FW-1:0] data_r, data_nxt;
  logic [FW-1:0] rb_r, rb_nxt;
  logic [BW-1:0] bits_r, bits_nxt;
  logic [PW-1:0] ph_r, ph_nxt;
  logic sclk_r, sclk_nxt;
  logic sdi_r, sdi_nxt;
  logic load_r, load_nxt;
  logic done_r, done_nxt;
  logic blank_r;

  wire ph_end = (ph_r == '0);

  // data changes on the falling link edge so it is stable half a
  // period on both sides of each rise
  always_comb begin
    st_nxt = st_r;
    data_nxt = data_r;
    rb_nxt = rb_r;
    bits_nxt = bits_r;
    ph_nxt = ph_end ? ph_r : ph_r - PH_ONE;
    sclk_nxt = sclk_r;
    sdi_nxt = sdi_r;
    load_nxt = load_r;
    done_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (start) begin
          data_nxt = frame_data;
          bits_nxt = BITS_ALL;
          sdi_nxt = frame_data[FW-1];
          ph_nxt = PH_HALF;
          st_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (ph_end) begin
          sclk_nxt = 1'b1;
          rb_nxt = {rb_r[FW-2:0], sout_s};
          ph_nxt = PH_HALF;
          st_nxt = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (ph_end) begin
          sclk_nxt = 1'b0;
          data_nxt = {data_r[FW-2:0], 1'b0};
          bits_nxt = bits_r - BITS_ONE;
          ph_nxt = PH_HALF;
          if (bits_r == BITS_ONE) begin
            load_nxt = 1'b1;
            ph_nxt = PH_LOAD;
            st_nxt = ST_LOAD;
          end else begin
            sdi_nxt = data_r[FW-2];
            st_nxt = ST_LOW;
          end
        end
      end
      ST_LOAD: begin
        if (ph_end) begin
          load_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      data_r <= '0;
      rb_r <= '0;
      bits_r <= '0;
      ph_r <= '0;
      sclk_r <= 1'h0;
      sdi_r <= 1'h0;
      load_r <= 1'h0;
      done_r <= 1'h0;
      blank_r <= BLANK_RESET;
    end else begin
      st_r <= st_nxt;
      data_r <= data_nxt;
      rb_r <= rb_nxt;
      bits_r <= bits_nxt;
      ph_r <= ph_nxt;
      sclk_r <= sclk_nxt;
      sdi_r <= sdi_nxt;
      load_r <= load_nxt;
      done_r <= done_nxt;
      blank_r <= blank_req;
    end
  end

  // ========================================================
  // outputs
  assign link.serial_clk = sclk_r;
  assign link.serial_in = sdi_r;
  assign link.latch_load = load_r;
  assign link.output_blank_n = blank_r;
  assign busy = (st_r != ST_IDLE);
  assign done = done_r;
  assign readback = rb_r;

endmodule

/* File: sim/lsl_asserts.sv */
`timescale 1ns/1ns
// ==========================================================
// link checker: watches both ends across the one interface
module lsl_asserts #(
  parameter int NUM_DEV = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link signals
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic latch_load,
  input wire logic output_blank_n
);
  import lsl_pkg::*;
  logic sclk_d_r;
  logic [WORD_BITS-1:0] mdl_r;
  logic [7:0] quiet_r;
  logic [7:0] rises_r;
  wire link_rise = serial_clk & ~sclk_d_r;
  // ==========================================================
  // reference shifter; the device lags by its synchroniser, so it
  // is compared one link rise later, when its output has settled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_r <= 1'h0;
      mdl_r <= SHIFT_RESET;
      quiet_r <= 8'hFF;
      rises_r <= 8'h00;
    end else begin
      sclk_d_r <= serial_clk;
      mdl_r <= link_rise ? {mdl_r[WORD_BITS-2:0], serial_in} : mdl_r;
      quiet_r <= link_rise ? 8'h00 : (quiet_r == 8'hFF ? quiet_r : quiet_r + 8'h01);
      rises_r <= latch_load ? 8'h00 : rises_r + {7'h00, link_rise};
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_order;
    link_rise |-> serial_out == mdl_r[WORD_BITS-1];
  endproperty
  a_order: assert property (p_order) else $error("serial out off its stage");
  property p_quiet;
    quiet_r > 8'h04 |-> $stable(serial_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("serial out moved without a rise");
  property p_din_hold;
    serial_clk |-> $stable(serial_in);
  endproperty
  a_din_hold: assert property (p_din_hold) else $error("serial in moved while high");
  property p_word;
    $rose(latch_load) |-> rises_r == NUM_DEV * WORD_BITS;
  endproperty
  a_word: assert property (p_word) else $error("wrong rise count per load");
  property p_load_idle;
    latch_load |-> !serial_clk;
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("load while clock high");
  property p_load_len;
    $rose(latch_load) |-> latch_load [*4] ##1 !latch_load;
  endproperty
  a_load_len: assert property (p_load_len) else $error("load pulse length wrong");
  property p_clk_high;
    $rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high phase wrong");
  property p_clk_low;
    $fell(serial_clk) |-> !serial_clk [*4];
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock low phase short");
  c_rise: cover property (link_rise);
  c_load: cover property ($rose(latch_load));
  c_blank: cover property ($fell(output_blank_n));
endmodule

/* File: sim/led_shift_latch_interface_tb.sv */
`timescale 1ns/1ns
// ==========================================================
// host and device joined over one link
module led_shift_latch_interface_tb;
  import lsl_pkg::*;
  localparam logic [15:0] ROW_D [5] = '{16'hA5C3, 16'h8001, 16'hFFFF, 16'h0000, 16'h7FFE};
  localparam logic ROW_B [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
  logic clk;
  logic rst;
  logic start;
  logic blank_req;
  logic [15:0] frame_data;
  logic [15:0] prev;
  int miscompares;
  int check_count;
  int wait_n;
  wire done;
  wire busy;
  wire word_full;
  wire [4:0] shift_count;
  wire blanked;
  wire [15:0] readback;
  wire [15:0] latch_value;
  wire [15:0] led_sense;
  wire [15:0] sink_oe;
  wire [15:0] sink_out;
  // open-drain pins: pulled up unless a sink is on
  wire [15:0] sink_pin = (sink_oe & sink_out) | ~sink_oe;
  lsl_if i_lsl_if ();
  lsl_host #(.NUM_DEV(1)) i_lsl_host (.clk(clk), .rst(rst), .link(i_lsl_if.host),
    .start(start), .frame_data(frame_data), .blank_req(blank_req), .busy(busy), .done(done),
    .readback(readback));
  lsl_device i_lsl_device (.clk(clk), .rst(rst), .link(i_lsl_if.device),
    .led_sink_in(sink_pin), .led_sink_out(sink_out), .led_sink_oe(sink_oe),
    .latch_value(latch_value), .led_sense(led_sense), .shift_count(shift_count),
    .word_full(word_full), .outputs_blanked(blanked));
  lsl_asserts #(.NUM_DEV(1)) i_lsl_asserts (.clk(clk), .rst(rst),
    .serial_clk(i_lsl_if.serial_clk), .serial_in(i_lsl_if.serial_in),
    .serial_out(i_lsl_if.serial_out), .latch_load(i_lsl_if.latch_load),
    .output_blank_n(i_lsl_if.output_blank_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task kick(input logic [15:0] d);
    frame_data = d;
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
  endtask
  task wait_done;
    int n;
    n = 0;
    while (n < 400 && done !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      give_verdict;
    end
  endtask
  // latch, pins and cascade once the device has caught up
  task expect_state(input logic [15:0] d, input logic b);
    repeat (6) @(posedge clk);
    #1;
    chk("latch_value", d, latch_value);
    chk("led_sink_oe", b ? 16'h0000 : d, sink_oe);
    chk("led_sense", b ? 16'hFFFF : ~d, led_sense);
    chk("outputs_blanked", {15'h0000, b}, {15'h0000, blanked});
    chk("readback", prev, readback);
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("shift_count", 16'h0000, {11'h000, shift_count});
    prev = d;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    start = 1'b0;
    blank_req = 1'b1;
    frame_data = 16'h0000;
    prev = 16'h0000;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      blank_req = ROW_B[i];
      kick(ROW_D[i]);
      wait_done;
      expect_state(ROW_D[i], ROW_B[i]);
      $display("row %0d finished", i);
    end
    // second start mid-frame is ignored, latch holds while shifting
    kick(16'h1234);
    repeat (40) @(posedge clk);
    #1;
    kick(16'hEDCB);
    chk("latch_value", prev, latch_value);
    wait_done;
    chk("readback", prev, readback);
    prev = 16'h1234;
    // next frame starts in the done cycle, back to back
    kick(16'h0F0F);
    repeat (20) @(posedge clk);
    #1;
    chk("latch_value", 16'h1234, latch_value);
    chk("busy", 16'h0001, {15'h0000, busy});
    wait_n = 0;
    while (wait_n < 200 && word_full !== 1'b1) begin
      @(posedge clk);
      #1;
      wait_n++;
    end
    chk("word_full", 16'h0001, {15'h0000, word_full});
    chk("shift_count", 16'h0010, {11'h000, shift_count});
    wait_done;
    expect_state(16'h0F0F, 1'b0);
    $display("busy start test finished");
    // reset in mid-frame clears the shift path and the sinks
    kick(16'hFFFF);
    repeat (30) @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("latch_value", LATCH_RESET, latch_value);
    chk("led_sink_oe", 16'h0000, sink_oe);
    chk("serial_out", 16'h0000, {15'h0000, i_lsl_if.serial_out});
    rst = 1'b0;
    prev = 16'h0000;
    kick(16'h3C3C);
    wait_done;
    expect_state(16'h3C3C, 1'b0);
    $display("reset test finished");
    give_verdict;
  end
endmodule
